// ===== verilog/bms_top.sv
`timescale 1ns/1ps
module bms_top (
   input  wire logic                   core_clk,
   input  wire logic                   srst,
   input  wire logic                   external_boot_pin,
   input  wire logic                   wide_address_pin,
   input  wire logic                   flash_secured,
   input  wire bms_pkg::bms_bus_s      bus,
   output logic [15:0]                 rdata,
   input  wire bms_pkg::bms_flash_rd_s core_data_read_bus,
   input  wire bms_pkg::bms_flash_rd_s secondary_data_bus,
   output bms_pkg::bms_flash_rd_s      flash_rd,
   output logic                        core_rd_grant,
   output logic                        sec_rd_grant,
   output logic                        flash_cmd_wr,
   output logic [15:0]                 flash_cmd_data,
   input  wire logic                   core_data_write_bus_wr,
   input  wire logic [15:0]            core_data_write_bus,
   output logic                        osc_high_drive_bit,
   output logic                        ext_prog_map,
   output logic                        external_boot,
   output logic [4:0]                  ext_addr_lines,
   output logic                        ext_prog_allowed,
   output logic                        debug_enable,
   output logic                        flash_unsecured,
   output logic                        mode_valid
);

   typedef struct packed {
      bms_pkg::bms_state_e state;
      logic                settle;
      logic                map_select_bit;
      logic                security_mode_bit;
      logic                sec_at_reset;
      logic                wide_at_reset;
      logic                boot_ext;
      logic                osc_high_drive_bit;
      logic                sec_bus_sel;
      logic                cmd_wr;
      logic [15:0]         cmd_data;
      logic [15:0]         rdata;
   } bms_top_s;

   bms_top_s st_ff;
   bms_top_s nxt_st;

   logic boot_pin_s;
   logic wide_pin_s;
   logic secured_s;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   bms_sync u_sync_boot (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (external_boot_pin),
      .q        (boot_pin_s)
   );

   bms_sync u_sync_wide (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (wide_address_pin),
      .q        (wide_pin_s)
   );

   bms_sync u_sync_sec (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (flash_secured),
      .q        (secured_s)
   );

   // ------------------------------------------------------------
   // Data flash read arbitration
   // ------------------------------------------------------------
   bms_flash_arb u_arb (
      .core_clk      (core_clk),
      .srst          (srst),
      .sel_secondary (st_ff.sec_bus_sel),
      .core_rd       (core_data_read_bus),
      .sec_rd        (secondary_data_bus),
      .flash_rd      (flash_rd),
      .core_grant    (core_rd_grant),
      .sec_grant     (sec_rd_grant)
   );

   function automatic logic hit(input bms_pkg::bms_bus_s b, input logic [3:0] ofs);
      hit = (b.addr == ofs);
   endfunction

   // ------------------------------------------------------------
   // Mode capture, register file and flash command path
   // ------------------------------------------------------------
   always_comb begin
      logic sec_n;
      logic map_n;
      sec_n  = ~secured_s;
      map_n  = boot_pin_s;
      nxt_st = st_ff;
      nxt_st.cmd_wr = 1'b0;
      case (st_ff.state)
         bms_pkg::BMS_ST_RESET: begin
            // Two cycles let the cleared pin synchronisers refill first.
            nxt_st.settle = 1'b1;
            if (st_ff.settle) begin
               nxt_st.state = bms_pkg::BMS_ST_LATCH;
            end
         end
         bms_pkg::BMS_ST_LATCH: begin
            // Capture the pins at once; the synchronisers settled during RESET.
            if ({sec_n, map_n} == bms_pkg::MODE_INVALID) begin
               map_n = 1'b0;
            end
            nxt_st.security_mode_bit = sec_n;
            nxt_st.sec_at_reset      = sec_n;
            nxt_st.map_select_bit    = map_n;
            nxt_st.boot_ext          = sec_n & map_n;
            nxt_st.wide_at_reset     = wide_pin_s & sec_n & map_n;
            nxt_st.state             = bms_pkg::BMS_ST_RUN;
         end
         bms_pkg::BMS_ST_RUN: begin
            if (bus.wr && hit(bus, bms_pkg::OFS_OPERATING_MODE)) begin
               nxt_st.map_select_bit    = bus.wdata[bms_pkg::BIT_MAP_SELECT];
               nxt_st.security_mode_bit = bus.wdata[bms_pkg::BIT_SECURITY_MODE];
            end
            if (bus.wr && hit(bus, bms_pkg::OFS_OSCILLATOR_CTRL)) begin
               nxt_st.osc_high_drive_bit = bus.wdata[bms_pkg::BIT_HIGH_DRIVE];
            end
            if (bus.wr && hit(bus, bms_pkg::OFS_FLASH_ACCESS)) begin
               nxt_st.sec_bus_sel = bus.wdata[bms_pkg::BIT_SEC_BUS_SEL];
            end
            if (core_data_write_bus_wr) begin
               nxt_st.cmd_wr   = 1'b1;
               nxt_st.cmd_data = core_data_write_bus;
            end
         end
         default: begin
            nxt_st.state = bms_pkg::BMS_ST_RESET;
         end
      endcase
      nxt_st.rdata = 16'h0000;
      if (bus.rd) begin
         if (hit(bus, bms_pkg::OFS_OPERATING_MODE)) begin
            nxt_st.rdata[bms_pkg::BIT_MAP_SELECT]    = st_ff.map_select_bit;
            nxt_st.rdata[bms_pkg::BIT_SECURITY_MODE] = st_ff.security_mode_bit;
         end else if (hit(bus, bms_pkg::OFS_OSCILLATOR_CTRL)) begin
            nxt_st.rdata[bms_pkg::BIT_HIGH_DRIVE] = st_ff.osc_high_drive_bit;
         end else if (hit(bus, bms_pkg::OFS_STATUS)) begin
            nxt_st.rdata[bms_pkg::BIT_WIDE_ADDR]     = st_ff.wide_at_reset;
            nxt_st.rdata[bms_pkg::BIT_EXT_BOOT]      = st_ff.boot_ext;
            nxt_st.rdata[bms_pkg::BIT_DEBUG_EN]      = st_ff.sec_at_reset;
            nxt_st.rdata[bms_pkg::BIT_EXT_PROG_OK]   = st_ff.sec_at_reset;
            nxt_st.rdata[bms_pkg::BIT_FLASH_SECURED] = ~st_ff.sec_at_reset;
         end else if (hit(bus, bms_pkg::OFS_FLASH_ACCESS)) begin
            nxt_st.rdata[bms_pkg::BIT_SEC_BUS_SEL] = st_ff.sec_bus_sel;
         end
      end
      if (srst) begin
         nxt_st                    = '0;
         nxt_st.state              = bms_pkg::BMS_ST_RESET;
         nxt_st.osc_high_drive_bit = bms_pkg::HIGH_DRIVE_RST;
         nxt_st.sec_bus_sel        = bms_pkg::SEC_BUS_SEL_RST;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata              = st_ff.rdata;
   assign osc_high_drive_bit = st_ff.osc_high_drive_bit;
   assign flash_cmd_wr       = st_ff.cmd_wr;
   assign flash_cmd_data     = st_ff.cmd_data;
   assign ext_prog_map       = st_ff.map_select_bit & st_ff.sec_at_reset;
   assign external_boot      = st_ff.boot_ext;
   assign ext_addr_lines     = st_ff.wide_at_reset ? 5'(bms_pkg::ADDR_LINES_WIDE)
                                                   : 5'(bms_pkg::ADDR_LINES_NARROW);
   assign ext_prog_allowed   = st_ff.sec_at_reset;
   assign debug_enable       = st_ff.sec_at_reset;
   assign flash_unsecured    = st_ff.sec_at_reset;
   assign mode_valid         = (st_ff.state == bms_pkg::BMS_ST_RUN);

endmodule // bms_top

// ===== verilog/bms_pkg.sv
package bms_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_OPERATING_MODE    = 4'h0;
   localparam logic [3:0] OFS_OSCILLATOR_CTRL   = 4'h1;
   localparam logic [3:0] OFS_STATUS            = 4'h2;
   localparam logic [3:0] OFS_FLASH_ACCESS      = 4'h3;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_MAP_SELECT    = 0;
   localparam int BIT_SECURITY_MODE = 1;
   localparam int BIT_HIGH_DRIVE    = 0;
   localparam int BIT_WIDE_ADDR     = 0;
   localparam int BIT_EXT_BOOT      = 1;
   localparam int BIT_DEBUG_EN      = 2;
   localparam int BIT_EXT_PROG_OK   = 3;
   localparam int BIT_FLASH_SECURED = 4;
   localparam int BIT_SEC_BUS_SEL   = 0;

   // ------------------------------------------------------------
   // Reset values, widths and mode codes
   // ------------------------------------------------------------
   localparam logic      HIGH_DRIVE_RST   = 1'b0;
   localparam logic      SEC_BUS_SEL_RST  = 1'b0;
   localparam int        ADDR_LINES_NARROW = 16;
   localparam int        ADDR_LINES_WIDE   = 20;
   localparam logic [1:0] MODE_INVALID    = 2'b01;
   localparam logic [1:0] MODE_INTERNAL   = 2'b00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      BMS_ST_RESET  = 3'b001,
      BMS_ST_LATCH  = 3'b010,
      BMS_ST_RUN    = 3'b100
   } bms_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bms_bus_s;

   typedef struct packed {
      logic [19:0] addr;
      logic        rd;
   } bms_flash_rd_s;

endpackage

// ===== verilog/bms_sync.sv
`timescale 1ns/1ps
module bms_sync (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic d,
   output logic      q
);

   typedef struct packed {
      logic s1;
      logic s2;
   } bms_sync_s;

   bms_sync_s st_ff;
   bms_sync_s nxt_st;

   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
      if (srst) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   assign q = st_ff.s2;

endmodule // bms_sync

// ===== verilog/bms_flash_arb.sv
`timescale 1ns/1ps
module bms_flash_arb (
   input  wire logic                   core_clk,
   input  wire logic                   srst,
   input  wire logic                   sel_secondary,
   input  wire bms_pkg::bms_flash_rd_s core_rd,
   input  wire bms_pkg::bms_flash_rd_s sec_rd,
   output bms_pkg::bms_flash_rd_s      flash_rd,
   output logic                        core_grant,
   output logic                        sec_grant
);

   typedef struct packed {
      bms_pkg::bms_flash_rd_s rd;
   } bms_arb_s;

   bms_arb_s st_ff;
   bms_arb_s nxt_st;

   // ------------------------------------------------------------
   // One read bus at a time
   // ------------------------------------------------------------
   assign core_grant = core_rd.rd & ~sel_secondary;
   assign sec_grant  = sec_rd.rd & sel_secondary;

   always_comb begin
      nxt_st = st_ff;
      if (sel_secondary) begin
         nxt_st.rd = sec_rd;
      end else begin
         nxt_st.rd = core_rd;
      end
      if (srst) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   assign flash_rd = st_ff.rd;

endmodule // bms_flash_arb

// ===== tb/bms_chk.sv
`timescale 1ns/1ps
module bms_chk (
   input wire logic                   core_clk,
   input wire logic                   srst,
   input wire bms_pkg::bms_bus_s      bus,
   input wire logic [15:0]            rdata,
   input wire bms_pkg::bms_flash_rd_s core_data_read_bus,
   input wire bms_pkg::bms_flash_rd_s flash_rd,
   input wire logic                   core_rd_grant,
   input wire logic                   sec_rd_grant,
   input wire logic                   flash_cmd_wr,
   input wire logic [15:0]            flash_cmd_data,
   input wire logic                   core_data_write_bus_wr,
   input wire logic [15:0]            core_data_write_bus,
   input wire logic                   osc_high_drive_bit,
   input wire logic                   external_boot,
   input wire logic [4:0]             ext_addr_lines,
   input wire logic                   flash_unsecured,
   input wire logic                   mode_valid
);
   // ------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   chk_grant_onehot: assert property (!(core_rd_grant && sec_rd_grant))
      else $error("both read grants high");
   chk_flash_rd_pass: assert property (!srst && core_rd_grant && core_data_read_bus.rd
      |=> flash_rd == $past(core_data_read_bus)) else $error("flash read not passed");
   chk_cmd_follow: assert property (core_data_write_bus_wr |=> flash_cmd_wr
      && flash_cmd_data == $past(core_data_write_bus)) else $error("flash word lost");
   chk_cmd_pulse: assert property (!core_data_write_bus_wr |=> !flash_cmd_wr)
      else $error("spurious flash word");
   chk_lines_narrow: assert property (!external_boot |-> ext_addr_lines == 5'h10)
      else $error("internal boot width wrong");
   chk_ext_boot_cfg: assert property (external_boot |-> flash_unsecured
      && ext_addr_lines inside {5'h10, 5'h14}) else $error("external boot config wrong");
   chk_mode_frozen: assert property (mode_valid && $past(mode_valid)
      |-> $stable(external_boot) && $stable(ext_addr_lines) && $stable(flash_unsecured))
      else $error("mode changed after capture");
   chk_valid_hold: assert property (mode_valid |=> mode_valid)
      else $error("mode valid dropped");
   chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_drive_reset: assert property ($fell(srst) |-> !osc_high_drive_bit)
      else $error("high drive set out of reset");
endmodule // bms_chk

// ===== tb/bms_strap_model.sv
`timescale 1ns/1ps
module bms_strap_model (
   input  wire logic boot_sel,
   input  wire logic wide_sel,
   input  wire logic secure_sel,
   output logic      external_boot_pin,
   output logic      wide_address_pin,
   output logic      flash_secured,
   output logic      clock_source_select
);
   // ------------------------------------------------------------
   // Board straps
   // ------------------------------------------------------------
   assign external_boot_pin = boot_sel;
   assign wide_address_pin = wide_sel;
   assign flash_secured = secure_sel;
   assign clock_source_select = 1'h1;
endmodule // bms_strap_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic                   core_clk = 1'h0;
   logic                   srst = 1'h1;
   logic                   boot_sel = 1'h0, wide_sel = 1'h0, secure_sel = 1'h1;
   logic                   external_boot_pin, wide_address_pin, flash_secured;
   logic                   clock_source_select;
   bms_pkg::bms_bus_s      bus = '0;
   bms_pkg::bms_flash_rd_s core_data_read_bus = '0, secondary_data_bus = '0, flash_rd;
   logic                   core_data_write_bus_wr = 1'h0;
   logic [15:0]            core_data_write_bus = 16'h0000, rdata, flash_cmd_data;
   logic                   core_rd_grant, sec_rd_grant, flash_cmd_wr, osc_high_drive_bit;
   logic                   ext_prog_map, external_boot, ext_prog_allowed, debug_enable;
   logic                   flash_unsecured, mode_valid;
   logic [4:0]             ext_addr_lines;
   int                     fails = 0, n_tests = 0, cyc = 0;
   logic [2:0]             md [5] = '{3'h4, 3'h7, 3'h1, 3'h2, 3'h3};
   logic [8:0]             ev [5] = '{9'h100, 9'h100, 9'h107, 9'h10F, 9'h14F};
   logic [4:0]             es [5] = '{5'h10, 5'h10, 5'h0C, 5'h0E, 5'h0F};
   logic [1:0]             er [5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h3};
   logic [8:0]             mode_out;
   assign mode_out = {ext_addr_lines, external_boot, flash_unsecured, debug_enable,
                      ext_prog_allowed};
   bms_top u_bms_top (
      .core_clk               (core_clk),
      .srst                   (srst),
      .external_boot_pin      (external_boot_pin),
      .wide_address_pin       (wide_address_pin),
      .flash_secured          (flash_secured),
      .bus                    (bus),
      .rdata                  (rdata),
      .core_data_read_bus     (core_data_read_bus),
      .secondary_data_bus     (secondary_data_bus),
      .flash_rd               (flash_rd),
      .core_rd_grant          (core_rd_grant),
      .sec_rd_grant           (sec_rd_grant),
      .flash_cmd_wr           (flash_cmd_wr),
      .flash_cmd_data         (flash_cmd_data),
      .core_data_write_bus_wr (core_data_write_bus_wr),
      .core_data_write_bus    (core_data_write_bus),
      .osc_high_drive_bit     (osc_high_drive_bit),
      .ext_prog_map           (ext_prog_map),
      .external_boot          (external_boot),
      .ext_addr_lines         (ext_addr_lines),
      .ext_prog_allowed       (ext_prog_allowed),
      .debug_enable           (debug_enable),
      .flash_unsecured        (flash_unsecured),
      .mode_valid             (mode_valid)
   );
   bms_strap_model u_bms_strap_model (
      .boot_sel            (boot_sel),
      .wide_sel            (wide_sel),
      .secure_sel          (secure_sel),
      .external_boot_pin   (external_boot_pin),
      .wide_address_pin    (wide_address_pin),
      .flash_secured       (flash_secured),
      .clock_source_select (clock_source_select)
   );
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         finish_test();
      end
   end
   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
      @(posedge core_clk);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
      @(posedge core_clk);
      bus <= '0;
      #1 chk(nm, e, rdata);
   endtask
   task automatic do_reset(input logic [2:0] m, input int n);
      @(posedge core_clk);
      {secure_sel, boot_sel, wide_sel} <= m;
      srst <= 1'h1;
      repeat (n) @(posedge core_clk);
      srst <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask
   task automatic finish_test();
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      do_reset(3'h4, 11);
      rd(4'h1, 16'h0000, "osc_ctrl");
      wr(4'h1, 16'h0001);
      chk("osc_high_drive_bit", 1'h1, osc_high_drive_bit);
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0000, "osc_ctrl");
      rd(4'hF, 16'h0000, "unmapped");
      @(posedge core_clk);
      core_data_read_bus <= '{addr: 20'h12345, rd: 1'h1};
      secondary_data_bus <= '{addr: 20'hABCDE, rd: 1'h1};
      core_data_write_bus_wr <= 1'h1;
      core_data_write_bus <= 16'hA5C3;
      #1 chk("grants", 2'h2, {core_rd_grant, sec_rd_grant});
      @(posedge core_clk);
      core_data_write_bus_wr <= 1'h0;
      #1 chk("flash_rd", 21'h02468B, flash_rd);
      chk("flash_cmd", 17'h1A5C3, {flash_cmd_wr, flash_cmd_data});
      wr(4'h3, 16'h0001);
      chk("grants", 2'h1, {core_rd_grant, sec_rd_grant});
      @(posedge core_clk);
      #1 chk("flash_rd", 21'h1579BD, flash_rd);
      rd(4'h3, 16'h0001, "flash_access");
      for (int i = 0; i < 5; i++) begin
         do_reset(md[i], 6);
         chk("mode_valid", 1'h1, mode_valid);
         chk("mode_out", ev[i], mode_out);
         @(posedge core_clk);
         secure_sel <= ~md[i][2];
         repeat (4) @(posedge core_clk);
         rd(4'h0, er[i], "mode_bits");
         rd(4'h2, {11'h000, es[i]}, "status");
         wr(4'h0, {er[i][1], 1'h1});
         chk("ext_prog_map", er[i][1], ext_prog_map);
         wr(4'h0, {~er[i][1], 1'h1});
         chk("ext_prog_map", er[i][1], ext_prog_map);
         chk("flash_unsecured", er[i][1], flash_unsecured);
         rd(4'h0, {~er[i][1], 1'h1}, "mode_bits");
         wr(4'h0, 16'h0000);
         chk("ext_prog_map", 1'h0, ext_prog_map);
      end
      finish_test();
   end
endmodule // tb
bind bms_top bms_chk u_bms_chk (
   .core_clk               (core_clk),
   .srst                   (srst),
   .bus                    (bus),
   .rdata                  (rdata),
   .core_data_read_bus     (core_data_read_bus),
   .flash_rd               (flash_rd),
   .core_rd_grant          (core_rd_grant),
   .sec_rd_grant           (sec_rd_grant),
   .flash_cmd_wr           (flash_cmd_wr),
   .flash_cmd_data         (flash_cmd_data),
   .core_data_write_bus_wr (core_data_write_bus_wr),
   .core_data_write_bus    (core_data_write_bus),
   .osc_high_drive_bit     (osc_high_drive_bit),
   .external_boot          (external_boot),
   .ext_addr_lines         (ext_addr_lines),
   .flash_unsecured        (flash_unsecured),
   .mode_valid             (mode_valid)
);
